// ===== design/odc_pin_control.sv
// pin level control of an octal 12-bit parallel input dac
//
// Overview of operation
// - data words are straight binary with format pin low, twos complement when high
// - command words are always decoded as straight binary
// - open-drain busy pulled low while the correction engine runs, released otherwise
// - clear low grounds all eight outputs through switch and resistor
// - clear high and load low connects all outputs to their amplifiers
// - monitor output three-stated or routed per the monitor selection register
// - channels zero to three form group a, four to seven group b
// - load low makes output latches transparent to the data registers
`timescale 1ns/1ns
`default_nettype none
module odc_pin_control (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic data_format_select_i,
	input wire logic output_clear_n_i,
	input wire logic output_latch_load_n_i,
	input wire logic wr_valid_i,
	input wire logic wr_is_data_i,
	input wire logic [2:0] wr_chan_i,
	input wire logic [11:0] wr_word_i,
	output logic [95:0] dac_code_o,
	output logic [7:0] out_to_amp_o,
	output logic [7:0] out_to_ground_o,
	output logic [7:0] group_b_sel_o,
	output logic [3:0] analog_monitor_out_sel_o,
	output logic analog_monitor_out_oe_n_o,
	output logic busy_o,
	output logic busy_oe_n_o
);
	logic fmt_twos;
	logic clear_n;
	logic load_n;
	logic [11:0] data_r [8];
	logic [11:0] latch_r [8];
	logic [3:0] mon_sel_r;
	logic amp_conn_r;
	odc_pkg::odc_engine_type engine_r;
	logic [7:0] corr_cnt_r;

	function automatic logic [11:0] to_offset_binary(input logic [11:0] w, input logic twos);
		to_offset_binary = twos ? {~w[odc_pkg::CODE_MSB], w[10:0]} : w;
	endfunction

	function automatic logic in_group_b(input logic [2:0] ch);
		in_group_b = (ch >= odc_pkg::GROUP_B_FIRST);
	endfunction

	odc_pin_sync #(.RESET_VAL(odc_pkg::PIN_RESET_LOW)) u_fmt_sync (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.pin_i(data_format_select_i),
		.level_o(fmt_twos)
	);
	odc_pin_sync #(.RESET_VAL(odc_pkg::PIN_RESET_HIGH)) u_clr_sync (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.pin_i(output_clear_n_i),
		.level_o(clear_n)
	);
	odc_pin_sync #(.RESET_VAL(odc_pkg::PIN_RESET_HIGH)) u_load_sync (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.pin_i(output_latch_load_n_i),
		.level_o(load_n)
	);

	// data registers
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < odc_pkg::NUM_CHAN; i++) begin
				data_r[i] <= odc_pkg::CODE_RESET;
			end
		end else if (wr_valid_i && wr_is_data_i) begin
			data_r[wr_chan_i] <= to_offset_binary(wr_word_i, fmt_twos);
		end
	end

	// command word: monitor selection, format pin ignored
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			mon_sel_r <= odc_pkg::MON_RESET;
		end else if (wr_valid_i && !wr_is_data_i) begin
			mon_sel_r <= wr_word_i[3:0];
		end
	end

	// output latches follow the data registers while load is low
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < odc_pkg::NUM_CHAN; i++) begin
				latch_r[i] <= odc_pkg::CODE_RESET;
			end
		end else if (!load_n) begin
			for (int i = 0; i < odc_pkg::NUM_CHAN; i++) begin
				latch_r[i] <= data_r[i];
			end
		end
	end

	always_comb begin
		for (int i = 0; i < odc_pkg::NUM_CHAN; i++) begin
			dac_code_o[i*12 +: 12] = latch_r[i];
		end
	end

	// output switches; with clear high and load high the last connection is held,
	// so outputs stay grounded after a clear until the next load
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			amp_conn_r <= 1'b0;
		end else if (!clear_n) begin
			amp_conn_r <= 1'b0;
		end else if (!load_n) begin
			amp_conn_r <= 1'b1;
		end
	end

	assign out_to_amp_o = {8{amp_conn_r}};
	assign out_to_ground_o = {8{~amp_conn_r}};

	always_comb begin
		for (int i = 0; i < odc_pkg::NUM_CHAN; i++) begin
			group_b_sel_o[i] = in_group_b(3'(i));
		end
	end

	// monitor mux; unused encodings three-state the pin rather than guess a source
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			analog_monitor_out_sel_o <= odc_pkg::MON_HIZ;
			analog_monitor_out_oe_n_o <= 1'b1;
		end else if (mon_sel_r == odc_pkg::MON_HIZ || mon_sel_r > odc_pkg::MON_OFFSET_B) begin
			analog_monitor_out_sel_o <= odc_pkg::MON_HIZ;
			analog_monitor_out_oe_n_o <= 1'b1;
		end else begin
			analog_monitor_out_sel_o <= mon_sel_r;
			analog_monitor_out_oe_n_o <= 1'b0;
		end
	end

	// correction engine: each data word restarts the run
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			engine_r <= odc_pkg::ODC_IDLE;
			corr_cnt_r <= 8'h00;
		end else if (wr_valid_i && wr_is_data_i) begin
			engine_r <= odc_pkg::ODC_CORRECT;
			corr_cnt_r <= 8'(odc_pkg::CORR_CYCLES - 1);
		end else begin
			case (engine_r)
				odc_pkg::ODC_IDLE: begin
					corr_cnt_r <= 8'h00;
				end
				odc_pkg::ODC_CORRECT: begin
					if (corr_cnt_r == 8'h00) begin
						engine_r <= odc_pkg::ODC_IDLE;
					end else begin
						corr_cnt_r <= corr_cnt_r - 8'h01;
					end
				end
				default: begin
					engine_r <= odc_pkg::ODC_IDLE;
				end
			endcase
		end
	end

	// open drain: drive low only, released pin is pulled up outside
	assign busy_o = 1'b0;
	assign busy_oe_n_o = (engine_r != odc_pkg::ODC_CORRECT);

	mon_hiz_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		!wr_is_data_i && wr_valid_i && wr_word_i[3:0] == odc_pkg::MON_HIZ
		##1 !(wr_valid_i && !wr_is_data_i) |=> analog_monitor_out_oe_n_o)
		else $error("monitor not three-stated");
	mon_route_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		wr_valid_i && !wr_is_data_i && wr_word_i[3:0] == odc_pkg::MON_REFBUF_A
		##1 !(wr_valid_i && !wr_is_data_i)
		|=> !analog_monitor_out_oe_n_o && analog_monitor_out_sel_o == odc_pkg::MON_REFBUF_A)
		else $error("monitor not routed");
	clear_ground_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		!clear_n |=> out_to_ground_o == 8'hff && out_to_amp_o == 8'h00)
		else $error("outputs not grounded under clear");
	load_connect_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		clear_n && !load_n |=> out_to_amp_o == 8'hff && out_to_ground_o == 8'h00)
		else $error("outputs not on amplifiers");
	latch_follow_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		!load_n |=> latch_r[0] == $past(data_r[0]) && latch_r[7] == $past(data_r[7]))
		else $error("latch not transparent");
	latch_hold_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		load_n |=> $stable(dac_code_o))
		else $error("latch changed while load high");
	twos_code_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		wr_valid_i && wr_is_data_i && fmt_twos
		|=> data_r[$past(wr_chan_i)] == {~$past(wr_word_i[11]), $past(wr_word_i[10:0])})
		else $error("twos complement word misdecoded");
	bin_code_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		wr_valid_i && wr_is_data_i && !fmt_twos
		|=> data_r[$past(wr_chan_i)] == $past(wr_word_i))
		else $error("straight binary word misdecoded");
	cmd_binary_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		wr_valid_i && !wr_is_data_i |=> mon_sel_r == $past(wr_word_i[3:0]))
		else $error("command word altered by format");
	busy_run_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		wr_valid_i && wr_is_data_i |=> !busy_oe_n_o [*8])
		else $error("busy not driven while correcting");
	// assertion helper: cycles since the last data word, saturating so it never wraps
	logic [7:0] since_word_r;
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			since_word_r <= 8'hff;
		end else if (wr_valid_i && wr_is_data_i) begin
			since_word_r <= 8'h00;
		end else if (since_word_r != 8'hff) begin
			since_word_r <= since_word_r + 8'h01;
		end
	end

	busy_release_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		busy_oe_n_o == (since_word_r >= 8'(odc_pkg::CORR_CYCLES)))
		else $error("busy not released after correction");
	group_split_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		group_b_sel_o == 8'hf0)
		else $error("group assignment wrong");

	clear_cycle_c: cover property (@(posedge mclk_i) disable iff (!resetn_i)
		!clear_n ##1 clear_n && !load_n ##2 out_to_amp_o == 8'hff);
	twos_write_c: cover property (@(posedge mclk_i) disable iff (!resetn_i)
		wr_valid_i && wr_is_data_i && fmt_twos ##1 !busy_oe_n_o);
	monitor_on_c: cover property (@(posedge mclk_i) disable iff (!resetn_i)
		!analog_monitor_out_oe_n_o);
endmodule
`default_nettype wire

// ===== design/odc_pkg.sv
// shared constants and the pin input synchroniser of the octal dac pin control block
package odc_pkg;
	localparam int NUM_CHAN = 8;
	localparam int CODE_W = 12;
	localparam int CHAN_W = 3;
	localparam int MON_W = 4;
	// position of the sign bit in a data word
	localparam int CODE_MSB = 11;
	// monitor selection encodings
	localparam logic [3:0] MON_HIZ = 4'h0;
	localparam logic [3:0] MON_CHAN0 = 4'h1;
	localparam logic [3:0] MON_CHAN7 = 4'h8;
	localparam logic [3:0] MON_REFBUF_A = 4'h9;
	localparam logic [3:0] MON_REFBUF_B = 4'ha;
	localparam logic [3:0] MON_OFFSET_A = 4'hb;
	localparam logic [3:0] MON_OFFSET_B = 4'hc;
	// reset values
	localparam logic [3:0] MON_RESET = 4'h0;
	localparam logic [11:0] CODE_RESET = 12'h000;
	localparam logic PIN_RESET_HIGH = 1'b1;
	localparam logic PIN_RESET_LOW = 1'b0;
	// first channel of group b
	localparam logic [2:0] GROUP_B_FIRST = 3'h4;
	// correction engine run time per data word
	localparam int CLK_PERIOD_NS = 8;
	localparam int CORR_TIME_NS = 1000;
	localparam int CORR_CYCLES = (CORR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CORR_CNT_W = 8;
	typedef enum logic [1:0] {
		ODC_IDLE = 2'b00,
		ODC_CORRECT = 2'b01
	} odc_engine_type;
endpackage

`timescale 1ns/1ns
`default_nettype none
module odc_pin_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic pin_i,
	output logic level_o
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			s1_r <= RESET_VAL;
			s2_r <= RESET_VAL;
			s3_r <= RESET_VAL;
		end else begin
			s1_r <= pin_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// a change is taken only once the second and third stages agree
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			level_o <= RESET_VAL;
		end else if (s2_r == s3_r) begin
			level_o <= s3_r;
		end
	end
endmodule
`default_nettype wire

// ===== verif/odc_host_model.sv
// bus master model that turns bench requests into one-cycle write strobes
`timescale 1ns/1ns
`default_nettype none
module odc_host_model (
	input wire logic mclk_i,
	input wire logic req_i,
	input wire logic req_is_data_i,
	input wire logic [2:0] req_chan_i,
	input wire logic [11:0] req_word_i,
	output logic wr_valid_o,
	output logic wr_is_data_o,
	output logic [2:0] wr_chan_o,
	output logic [11:0] wr_word_o
);
	initial begin
		wr_valid_o = 1'b0;
		wr_is_data_o = 1'b0;
		wr_chan_o = 3'h0;
		wr_word_o = 12'h000;
	end
	always @(posedge mclk_i) begin
		wr_valid_o <= req_i;
		if (req_i) begin
			wr_is_data_o <= req_is_data_i;
			wr_chan_o <= req_chan_i;
			wr_word_o <= req_word_i;
		end else begin
			// an idle bus must not look like it still holds the last word
			wr_is_data_o <= ~wr_is_data_o;
			wr_chan_o <= ~wr_chan_o;
			wr_word_o <= ~wr_word_o;
		end
	end
endmodule
`default_nettype wire

// ===== verif/odc_pin_control_tb.sv
// self-checking bench for the octal dac pin control block
`timescale 1ns/1ns
`default_nettype none
module odc_pin_control_tb;
	logic mclk_i = 1'b0, resetn_i = 1'b0, fmt = 1'b0, clr_n = 1'b1, ld_n = 1'b1;
	logic req = 1'b0, req_d = 1'b0;
	logic [2:0] req_c = 3'h0;
	logic [11:0] req_w = 12'h000;
	logic wv, wd;
	logic [2:0] wc;
	logic [11:0] ww;
	logic [95:0] code;
	logic [7:0] amp, gnd, grp;
	logic [3:0] msel;
	logic moe_n, busy, busy_oe_n;
	int num_errors = 0, n_tests = 0, cyc = 0;
	initial forever #4 mclk_i = ~mclk_i;
	odc_host_model odc_host_model_i (.mclk_i(mclk_i), .req_i(req), .req_is_data_i(req_d),
		.req_chan_i(req_c), .req_word_i(req_w), .wr_valid_o(wv), .wr_is_data_o(wd),
		.wr_chan_o(wc), .wr_word_o(ww));
	odc_pin_control odc_pin_control_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
		.data_format_select_i(fmt), .output_clear_n_i(clr_n), .output_latch_load_n_i(ld_n),
		.wr_valid_i(wv), .wr_is_data_i(wd), .wr_chan_i(wc), .wr_word_i(ww),
		.dac_code_o(code), .out_to_amp_o(amp), .out_to_ground_o(gnd), .group_b_sel_o(grp),
		.analog_monitor_out_sel_o(msel), .analog_monitor_out_oe_n_o(moe_n),
		.busy_o(busy), .busy_oe_n_o(busy_oe_n));
	task automatic give_verdict();
		$display("errors %0d tests %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// ceiling is about twelve times the expected run length
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			give_verdict();
		end
	end
	task automatic chk(input logic [95:0] got, input logic [95:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task automatic wr(input logic d, input logic [2:0] c, input logic [11:0] w);
		@(posedge mclk_i);
		req <= 1'b1;
		req_d <= d;
		req_c <= c;
		req_w <= w;
		@(posedge mclk_i);
		req <= 1'b0;
		tick(4);
	endtask
	initial begin
		tick(6);
		chk(code, '0);
		chk({amp, gnd, grp}, 24'h00fff0);
		chk({msel, moe_n, busy_oe_n}, 6'h03);
		@(posedge mclk_i) resetn_i <= 1'b1;
		ld_n <= 1'b0;
		tick(7);
		chk({amp, gnd}, 16'hff00);
		wr(1'b1, 3'h5, 12'h123);
		chk(code[71:60], 12'h123);
		chk({busy, busy_oe_n}, 2'b00);
		@(posedge mclk_i) fmt <= 1'b1;
		tick(6);
		wr(1'b1, 3'h0, 12'h123);
		wr(1'b1, 3'h7, 12'h800);
		chk({code[95:84], code[11:0]}, 24'h000923);
		wr(1'b0, 3'h0, 12'h00b);
		chk({msel, moe_n}, 5'h16);
		wr(1'b0, 3'h0, 12'h009);
		chk({msel, moe_n}, 5'h12);
		wr(1'b0, 3'h0, 12'h00e);
		chk(moe_n, 1'b1);
		wr(1'b0, 3'h0, 12'h000);
		chk({msel, moe_n}, 5'h01);
		wr(1'b0, 3'h0, 12'h003);
		chk({msel, moe_n}, 5'h06);
		tick(140);
		chk(busy_oe_n, 1'b1);
		@(posedge mclk_i) ld_n <= 1'b1;
		tick(6);
		wr(1'b1, 3'h1, 12'h0ff);
		chk(code[23:12], 12'h000);
		@(posedge mclk_i) clr_n <= 1'b0;
		tick(7);
		chk({amp, gnd}, 16'h00ff);
		@(posedge mclk_i) ld_n <= 1'b0;
		tick(6);
		chk({amp, gnd}, 16'h00ff);
		chk(code[23:12], 12'h8ff);
		@(posedge mclk_i) clr_n <= 1'b1;
		tick(7);
		chk({amp, gnd}, 16'hff00);
		give_verdict();
	end
endmodule
`default_nettype wire
